// >>> crs_clock_seq.sv
// Core clock ratio selection, divided clocks and core reset release
`timescale 1ns/100ps
`default_nettype none
`include "crs_consts.svh"

// Functional notes
// R1: The ratio select pins are captured while the external reset is low.
// R2: Pin code 00 gives ratio 6, code 01 gives 32 and code 10 gives 16.
// R3: Software may override the pin ratio through the power control register.
// R4: Full core speed needs software to program the multiplier bits.
// R5: Software keeps the resulting core clock period within 2.5 ns to 10 ns.
// R6: The peripheral clock period is exactly two core clock periods.
// R7: Each serial port clock period is the peripheral period times its divider.
// R8: The SPI clock period is the peripheral period times the SPI divider.
// R9: Core reset stays on for 4096 input clocks plus 2 core clocks after release.
// R10: A late release may add one input clock, giving at most 4097 cycles.
// R11: Later external resets stay low at least 4 input clock cycles.
// R12: Control inputs are stable 20 input clocks before reset release.
// R13: The input clock runs stable 10 us before reset release.
// R14: Bit 12 picks clock or reset-out for the local clock pin, reset-out first.
// R15: Ratio code 11 is reserved and should not be presented.
module crs_clock_seq
   import crs_pkg::*;
#(
   parameter int NUM_PORTS = 4,
   parameter int RST_HOLD_CYCLES = `CRS_RST_HOLD_CK
) (
   input wire logic ref_clk_i, // Core clock, 125 MHz
   input wire logic nrst_i, // Synchronous reset, active low
   input wire logic ext_reset_n_i, // External reset pin, active low
   input wire logic [1:0] core_ratio_select_pins_i, // Ratio straps
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB direction
   input wire logic [`CRS_ADDR_W-1:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i, // APB write data
   output logic [31:0] prdata_o, // APB read data
   output logic pready_o, // APB ready
   output logic pslverr_o, // APB error, unmapped address
   output logic core_rst_n_o, // Internal core reset, active low
   output logic input_clock_tick_o, // One pulse per input clock
   output logic periph_clk_o, // Peripheral clock, half core rate
   output logic [NUM_PORTS-1:0] serial_port_clk_o, // Serial port clocks
   output logic spi_clk_o, // SPI clock
   output logic local_clock_output_o, // Clock or reset-out pin
   output logic ratio_code_reserved_o // Reserved strap code seen
);

   // One extra tick: the first one only aligns to the input clock edge
   localparam int CW = 14;
   localparam logic [CW-1:0] HOLD_LAST = CW'(RST_HOLD_CYCLES);

   generate
      if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
         $error("NUM_PORTS must be 1 to 4");
      end
      if (RST_HOLD_CYCLES < 1 || RST_HOLD_CYCLES > 8192) begin : g_bad_hold
         $error("RST_HOLD_CYCLES must be 1 to 8192");
      end
   endgenerate

   typedef struct packed {
      logic [1:0] ratio_code;
      logic code_rsvd;
      logic [5:0] in_cnt;
      logic in_tick;
      crs_rst_state_t rst_state;
      logic [CW-1:0] rst_cnt;
      logic [1:0] tail_cnt;
      logic [5:0] pm_mult;
      logic pm_ovr;
      logic pm_clksel;
      logic [15:0] spi_div;
      logic [NUM_PORTS-1:0][15:0] sp_div;
      logic [16:0] spi_cnt;
      logic [NUM_PORTS-1:0][16:0] sp_cnt;
      logic pclk;
      logic [31:0] rdata;
   } crs_state_t;

   crs_state_t s;
   crs_state_t next_s;

   logic [5:0] pin_ratio;
   logic [5:0] ratio;
   logic in_reset;
   logic acc;
   logic hit;
   logic [31:0] rd_val;

   // Straps decoded; reserved code falls back to the slowest safe ratio
   always_comb begin
      case (s.ratio_code)
         `CRS_CODE_R6: pin_ratio = `CRS_RATIO_6; // R2
         `CRS_CODE_R32: pin_ratio = `CRS_RATIO_32; // R2
         `CRS_CODE_R16: pin_ratio = `CRS_RATIO_16; // R2
         default: pin_ratio = `CRS_RATIO_6; // R15
      endcase
   end

   // Too small a multiplier cannot make an input clock, so it is ignored
   assign ratio = (s.pm_ovr && s.pm_mult >= `CRS_RATIO_MIN)
      ? s.pm_mult : pin_ratio; // R3 R4
   assign in_reset = (s.rst_state != CRS_RUN);
   assign acc = psel_i && penable_i;

   always_comb begin
      hit = 1'b1;
      rd_val = 32'h0000_0000;
      if (paddr_i == `CRS_OFF_POWER_MGMT_CONTROL_REG) begin
         rd_val[`CRS_PM_MULT_MSB:`CRS_PM_MULT_LSB] = s.pm_mult;
         rd_val[`CRS_PM_OVR_BIT] = s.pm_ovr;
         rd_val[`CRS_PM_CLKSEL_BIT] = s.pm_clksel;
      end else if (paddr_i == `CRS_OFF_SPIDIV) begin
         rd_val[15:0] = s.spi_div;
      end else if (paddr_i == `CRS_OFF_STATUS) begin
         rd_val[`CRS_ST_CODE_LSB +: 2] = s.ratio_code;
         rd_val[`CRS_ST_RSVD_BIT] = s.code_rsvd;
         rd_val[`CRS_ST_INRST_BIT] = in_reset;
         rd_val[`CRS_ST_RATIO_LSB +: 6] = ratio;
      end else begin
         hit = 1'b0;
         for (int i = 0; i < NUM_PORTS; i++) begin
            if (paddr_i == `CRS_OFF_SPDIV0 + `CRS_ADDR_W'(4 * i)) begin
               hit = 1'b1;
               rd_val[15:0] = s.sp_div[i];
            end
         end
      end
   end

   always_comb begin
      next_s = s;

      // Input clock modelled as one tick every ratio core cycles
      next_s.in_tick = 1'b0;
      if (s.in_cnt >= ratio - 6'h01) begin
         next_s.in_cnt = 6'h00;
         next_s.in_tick = 1'b1;
      end else begin
         next_s.in_cnt = s.in_cnt + 6'h01;
      end

      // Reset release sequence
      case (s.rst_state)
         CRS_HOLD: begin
            next_s.rst_cnt = '0;
            next_s.tail_cnt = 2'h0;
            if (ext_reset_n_i) begin
               next_s.rst_state = CRS_COUNT;
            end
         end
         CRS_COUNT: begin
            // First tick aligns, its phase is the late-release slot;
            // the full count follows, so the hold never falls short
            if (s.in_tick) begin // R10
               if (s.rst_cnt == HOLD_LAST) begin
                  next_s.rst_state = CRS_TAIL; // R9
               end else begin
                  next_s.rst_cnt = s.rst_cnt + CW'(1); // R9
               end
            end
         end
         CRS_TAIL: begin
            next_s.tail_cnt = s.tail_cnt + 2'h1;
            if (s.tail_cnt == `CRS_RST_TAIL_CORE_CLOCK - 2'h1) begin
               next_s.rst_state = CRS_RUN; // R9
            end
         end
         CRS_RUN: begin
            next_s.rst_state = CRS_RUN;
         end
         default: begin
            next_s.rst_state = CRS_HOLD;
         end
      endcase
      if (!ext_reset_n_i) begin
         next_s.rst_state = CRS_HOLD;
         next_s.ratio_code = core_ratio_select_pins_i; // R1
         next_s.code_rsvd = (core_ratio_select_pins_i == 2'h3); // R15
         next_s.pm_mult = '0;
         next_s.pm_ovr = 1'b0;
         next_s.pm_clksel = 1'b0; // R14
      end

      // Divided clocks run only once the core is out of reset
      if (in_reset) begin
         next_s.pclk = 1'b0;
         next_s.spi_cnt = '0;
         next_s.sp_cnt = '0;
      end else begin
         next_s.pclk = ~s.pclk; // R6
         if (s.spi_cnt >= {s.spi_div, 1'b0} - 17'h1) begin
            next_s.spi_cnt = '0; // R8
         end else begin
            next_s.spi_cnt = s.spi_cnt + 17'h1; // R8
         end
         for (int i = 0; i < NUM_PORTS; i++) begin
            if (s.sp_cnt[i] >= {s.sp_div[i], 1'b0} - 17'h1) begin
               next_s.sp_cnt[i] = '0; // R7
            end else begin
               next_s.sp_cnt[i] = s.sp_cnt[i] + 17'h1; // R7
            end
         end
      end

      // Register bus; read data prepared in setup, valid in access
      if (psel_i && !penable_i) begin
         next_s.rdata = rd_val;
      end
      if (acc && pwrite_i && ext_reset_n_i) begin
         if (paddr_i == `CRS_OFF_POWER_MGMT_CONTROL_REG) begin
            next_s.pm_mult =
               pwdata_i[`CRS_PM_MULT_MSB:`CRS_PM_MULT_LSB]; // R3
            next_s.pm_ovr = pwdata_i[`CRS_PM_OVR_BIT]; // R3
            next_s.pm_clksel = pwdata_i[`CRS_PM_CLKSEL_BIT]; // R14
         end else if (paddr_i == `CRS_OFF_SPIDIV) begin
            // Zero would stop the clock, so it reads back as one
            next_s.spi_div = (pwdata_i[15:0] == 16'h0000)
               ? 16'h0001 : pwdata_i[15:0]; // R8
         end
         for (int i = 0; i < NUM_PORTS; i++) begin
            if (paddr_i == `CRS_OFF_SPDIV0 + `CRS_ADDR_W'(4 * i)) begin
               next_s.sp_div[i] = (pwdata_i[15:0] == 16'h0000)
                  ? 16'h0001 : pwdata_i[15:0]; // R7
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         s.ratio_code <= `CRS_CODE_R6;
         s.code_rsvd <= 1'b0;
         s.in_cnt <= 6'h00;
         s.in_tick <= 1'b0;
         s.rst_state <= CRS_HOLD;
         s.rst_cnt <= '0;
         s.tail_cnt <= 2'h0;
         s.pm_mult <= 6'(`CRS_PM_RESET);
         s.pm_ovr <= 1'b0;
         s.pm_clksel <= 1'b0; // R14
         s.spi_div <= `CRS_DIV_RESET;
         for (int i = 0; i < NUM_PORTS; i++) begin
            s.sp_div[i] <= `CRS_DIV_RESET;
         end
         s.spi_cnt <= '0;
         s.sp_cnt <= '0;
         s.pclk <= 1'b0;
         s.rdata <= 32'h0000_0000;
      end else begin
         s <= next_s;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++) begin : g_serial_port
         // High for the first half of each divided period
         assign serial_port_clk_o[g] =
            (s.sp_cnt[g] < {1'b0, s.sp_div[g]}); // R7
      end
   endgenerate

   assign spi_clk_o = (s.spi_cnt < {1'b0, s.spi_div}); // R8
   assign periph_clk_o = s.pclk; // R6
   assign core_rst_n_o = !in_reset; // R9
   assign input_clock_tick_o = s.in_tick;
   // Core clock itself cannot leave a flop; the half-rate clock stands in
   assign local_clock_output_o = s.pm_clksel ? s.pclk : !in_reset; // R14
   assign ratio_code_reserved_o = s.code_rsvd; // R15
   assign prdata_o = s.rdata;
   assign pready_o = 1'b1;
   assign pslverr_o = acc && !hit;

endmodule // crs_clock_seq

`default_nettype wire

// >>> crs_consts.svh
// Register map, field positions, reset values and counts of the clock sequencer
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH

`define CRS_ADDR_W 8
`define CRS_OFF_POWER_MGMT_CONTROL_REG 8'h00
`define CRS_OFF_SPIDIV 8'h04
`define CRS_OFF_SPDIV0 8'h08
`define CRS_OFF_STATUS 8'h18

`define CRS_PM_MULT_LSB 0
`define CRS_PM_MULT_MSB 5
`define CRS_PM_OVR_BIT 6
`define CRS_PM_CLKSEL_BIT 12
`define CRS_PM_RESET 32'h0000_0000

`define CRS_ST_CODE_LSB 0
`define CRS_ST_RSVD_BIT 2
`define CRS_ST_INRST_BIT 3
`define CRS_ST_RATIO_LSB 8

`define CRS_CODE_R6 2'h0
`define CRS_CODE_R32 2'h1
`define CRS_CODE_R16 2'h2
`define CRS_RATIO_6 6'h06
`define CRS_RATIO_32 6'h20
`define CRS_RATIO_16 6'h10
`define CRS_RATIO_MIN 6'h02

`define CRS_DIV_RESET 16'h0001
`define CRS_RST_TAIL_CORE_CLOCK 2'h2
`define CRS_RST_HOLD_CK 4096

`endif

// >>> crs_pkg.sv
// Types shared by the clock ratio and reset sequencer
`default_nettype none

package crs_pkg;

   typedef enum logic [1:0] {
      CRS_HOLD,
      CRS_COUNT,
      CRS_TAIL,
      CRS_RUN
   } crs_rst_state_t;

endpackage

`default_nettype wire

// >>> crs_seq_chk_sva.sv
// Assertion checker for the clock sequencer ports
`timescale 1ns/100ps
`default_nettype none
module crs_seq_chk
   import crs_pkg::*;
#(
   parameter int NUM_PORTS = 4,
   parameter int RST_HOLD_CYCLES = 4096
) (
   input wire logic ref_clk_i, // Clock
   input wire logic nrst_i, // Reset
   input wire logic ext_reset_n_i, // Pin reset
   input wire logic [1:0] core_ratio_select_pins_i, // Straps
   input wire logic core_rst_n_o, // Core reset
   input wire logic input_clock_tick_o, // Tick
   input wire logic periph_clk_o, // Half rate
   input wire logic [NUM_PORTS-1:0] serial_port_clk_o, // Port clocks
   input wire logic spi_clk_o, // SPI clock
   input wire logic local_clock_output_o, // Pin out
   input wire logic ratio_code_reserved_o // Flag
);
   logic [15:0] cnt_q;
   logic [15:0] gap_q;
   logic [5:0] r_q;
   logic ok_q;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // Ratio is fixed by the last strap sample taken while the pin is low
   always_ff @(posedge ref_clk_i) begin
      cnt_q <= (!nrst_i || !ext_reset_n_i) ? 16'h0000 : cnt_q + 16'h0001;
      gap_q <= input_clock_tick_o ? 16'h0000 : gap_q + 16'h0001;
      ok_q <= nrst_i && ext_reset_n_i && (ok_q || input_clock_tick_o);
      if (!nrst_i)
         r_q <= 6'h06;
      else if (!ext_reset_n_i)
         r_q <= core_ratio_select_pins_i == 2'h1 ? 6'h20 :
                core_ratio_select_pins_i == 2'h2 ? 6'h10 : 6'h06;
   end
   property p_cap;
      !ext_reset_n_i |=>
         ratio_code_reserved_o == (&$past(core_ratio_select_pins_i));
   endproperty
   a_cap: assert property (p_cap) else $error("flag not from straps");
   property p_hold;
      ext_reset_n_i && $past(ext_reset_n_i) |-> $stable(ratio_code_reserved_o);
   endproperty
   a_hold: assert property (p_hold) else $error("strap moved");
   property p_tick;
      input_clock_tick_o && ok_q && !core_rst_n_o |->
         gap_q + 16'h0001 == {10'h000, r_q};
   endproperty
   a_tick: assert property (p_tick) else $error("bad tick spacing");
   property p_pclk;
      core_rst_n_o [*3] |-> periph_clk_o != $past(periph_clk_o);
   endproperty
   a_pclk: assert property (p_pclk) else $error("no half rate");
   property p_div;
      !core_rst_n_o [*3] |-> (&serial_port_clk_o) && spi_clk_o;
   endproperty
   a_div: assert property (p_div) else $error("divider not idle");
   property p_rmin;
      $rose(core_rst_n_o) |->
         int'(cnt_q) >= RST_HOLD_CYCLES * int'(r_q) + 2;
   endproperty
   a_rmin: assert property (p_rmin) else $error("early release");
   property p_rmax;
      ext_reset_n_i && !core_rst_n_o |->
         int'(cnt_q) <= (RST_HOLD_CYCLES + 1) * int'(r_q) + 2;
   endproperty
   a_rmax: assert property (p_rmax) else $error("late release");
   property p_lco;
      !ext_reset_n_i |=> local_clock_output_o == core_rst_n_o;
   endproperty
   a_lco: assert property (p_lco) else $error("pin not reset-out");
   c_rel: cover property ($rose(core_rst_n_o));
   c_rsv: cover property (ratio_code_reserved_o && core_rst_n_o);
   c_clk: cover property (core_rst_n_o && !local_clock_output_o);
endmodule // crs_seq_chk
`default_nettype wire

// >>> crs_ext_src.sv
// Board reset source and strap pins model
`timescale 1ns/100ps
`default_nettype none
module crs_ext_src #(
   parameter int SETUP_TICKS = 20,
   parameter int STABLE_CYCLES = 1250
) (
   input wire logic clk_i, // Core clock
   input wire logic tick_i, // Input clock tick
   input wire logic req_i, // Request a reset
   input wire logic [1:0] code_i, // Strap code
   output var logic ext_reset_n_o, // Reset pin
   output var logic [1:0] straps_o // Strap pins
);
   int n;
   int up;
   initial begin
      ext_reset_n_o = 1'b0;
      straps_o = 2'h0;
      n = 0;
      up = 0;
   end
   always @(posedge clk_i) begin
      // 10 us of running clock at 8 ns before the first release
      if (up < STABLE_CYCLES)
         up <= up + 1;
      if (req_i) begin
         ext_reset_n_o <= 1'b0;
         straps_o <= code_i;
         n <= 0;
      end else if (!ext_reset_n_o) begin
         // Ticks stand in for a running input clock
         if (tick_i)
            n <= n + 1;
         if (n >= SETUP_TICKS && up >= STABLE_CYCLES)
            ext_reset_n_o <= 1'b1;
      end
   end
endmodule // crs_ext_src
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the clock sequencer
`timescale 1ns/100ps
`default_nettype none
`include "crs_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
   import crs_pkg::*;
;
   typedef struct packed {
      logic [1:0] code;
      logic [5:0] ratio;
      logic rsv;
   } crs_row_t;
   localparam crs_row_t ROWS [4] = '{'{2'h0, 6'h06, 1'h0},
      '{2'h1, 6'h20, 1'h0}, '{2'h2, 6'h10, 1'h0}, '{2'h3, 6'h06, 1'h1}};
   logic clk = 1'b0;
   logic nrst, psel, penable, pwrite, req, pready, pslverr, rsv, ext_n;
   logic core_rst_n, tick, pclk, spi_clk, lco, e;
   logic [1:0] code;
   logic [1:0] straps;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] r;
   logic [3:0] sp_clk;
   int miscompares = 0;
   int tests_run = 0;
   int n;
   always #4 clk = ~clk;
   crs_clock_seq #(.RST_HOLD_CYCLES(8)) crs_clock_seq_inst (.ref_clk_i(clk),
      .nrst_i(nrst), .ext_reset_n_i(ext_n), .core_ratio_select_pins_i(straps),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .core_rst_n_o(core_rst_n),
      .input_clock_tick_o(tick), .periph_clk_o(pclk),
      .serial_port_clk_o(sp_clk), .spi_clk_o(spi_clk),
      .local_clock_output_o(lco), .ratio_code_reserved_o(rsv));
   crs_ext_src crs_ext_src_inst (.clk_i(clk), .tick_i(tick), .req_i(req),
      .code_i(code), .ext_reset_n_o(ext_n), .straps_o(straps));
   task automatic complete_run;
      $display("checks %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (i == 50) begin
         miscompares++;
         complete_run();
      end
   endtask
   function automatic logic cur(input int s);
      return s == 0 ? spi_clk : s == 1 ? sp_clk[0] : core_rst_n;
   endfunction
   task automatic wt(input int s, input logic v);
      for (int i = 0; i < 2000; i++) begin
         @(posedge clk);
         if (cur(s) === v)
            return;
      end
      miscompares++;
      complete_run();
   endtask
   task automatic hi_run(input int s);
      wt(s, 1'b0);
      wt(s, 1'b1);
      n = 0;
      while (cur(s) === 1'b1 && n < 99) begin
         n++;
         @(posedge clk);
      end
   endtask
   task automatic ext_rst(input logic [1:0] c);
      code <= c;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      wt(2, 1'b0);
      wt(2, 1'b1);
   endtask
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      req = 1'b1;
      code = 2'h0;
      repeat (6) @(posedge clk);
      `CHK(core_rst_n, 1'b0)
      nrst <= 1'b1;
      req <= 1'b0;
      wt(2, 1'b1);
      for (int k = 0; k < 4; k++) begin
         ext_rst(ROWS[k].code);
         apb(1'b0, `CRS_OFF_STATUS, 32'h0);
         `CHK(r[13:0], {ROWS[k].ratio, 5'h00, ROWS[k].rsv, ROWS[k].code})
         `CHK(rsv, ROWS[k].rsv)
         $display("strap row %0d done", k);
      end
      apb(1'b1, `CRS_OFF_POWER_MGMT_CONTROL_REG, 32'h0000_1000);
      repeat (3) begin
         @(posedge clk);
         `CHK(lco, pclk)
      end
      // Multiplier 8 overrides the straps; one below the floor falls back to them
      apb(1'b1, `CRS_OFF_POWER_MGMT_CONTROL_REG, 32'h0000_0048);
      apb(1'b0, `CRS_OFF_STATUS, 32'h0);
      `CHK(r[13:8], 6'h08)
      apb(1'b1, `CRS_OFF_POWER_MGMT_CONTROL_REG, 32'h0000_0041);
      apb(1'b0, `CRS_OFF_STATUS, 32'h0);
      `CHK(r[13:8], 6'h06)
      $display("clock select and override done");
      apb(1'b1, `CRS_OFF_SPIDIV, 32'h0000_0003);
      hi_run(0);
      `CHK(n, 3)
      apb(1'b1, `CRS_OFF_SPDIV0, 32'h0000_0000);
      apb(1'b0, `CRS_OFF_SPDIV0, 32'h0);
      `CHK(r, 32'h0000_0001)
      hi_run(1);
      `CHK(n, 1)
      apb(1'b1, `CRS_OFF_SPDIV0 + 8'h0C, 32'h0000_0002);
      apb(1'b0, `CRS_OFF_SPDIV0 + 8'h0C, 32'h0);
      `CHK(r, 32'h0000_0002)
      apb(1'b0, 8'h40, 32'h0);
      `CHK({e, r}, 33'h1_0000_0000)
      $display("dividers and unmapped done");
      apb(1'b1, `CRS_OFF_POWER_MGMT_CONTROL_REG, 32'h0000_1000);
      ext_rst(2'h0);
      apb(1'b0, `CRS_OFF_POWER_MGMT_CONTROL_REG, 32'h0);
      `CHK(r, `CRS_PM_RESET)
      `CHK({lco, core_rst_n}, 2'h3)
      $display("pin reset default done");
      complete_run();
   end
endmodule // testbench
bind crs_clock_seq crs_seq_chk #(.NUM_PORTS(NUM_PORTS),
   .RST_HOLD_CYCLES(RST_HOLD_CYCLES)) crs_seq_chk_inst (
   .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ext_reset_n_i(ext_reset_n_i),
   .core_ratio_select_pins_i(core_ratio_select_pins_i),
   .core_rst_n_o(core_rst_n_o), .input_clock_tick_o(input_clock_tick_o),
   .periph_clk_o(periph_clk_o), .serial_port_clk_o(serial_port_clk_o),
   .spi_clk_o(spi_clk_o), .local_clock_output_o(local_clock_output_o),
   .ratio_code_reserved_o(ratio_code_reserved_o));
`default_nettype wire
